// File: common/twr_pkg.sv
// Shared constants for the two-wire register access link.
// Assumes both ends run on clk_sys at 20 MHz with synchronous reset.
package twr_pkg;
    // ----------------------------------------------------------------
    // Addressing
    // ----------------------------------------------------------------
    localparam logic [6:0] TWR_SLAVE_ADDR = 7'h3d;
    localparam logic TWR_DIR_WRITE = 1'b0;
    localparam logic TWR_DIR_READ = 1'b1;
    localparam int TWR_REG_AW = 16;
    localparam int TWR_REG_DW = 16;
    localparam int TWR_REG_DEPTH_LOG2 = 6;
    localparam logic [15:0] TWR_REG_RESET = 16'h0000;
    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int TWR_CLK_NS = 50;
    localparam int TWR_SCL_HALF_NS = 1250;
    localparam int TWR_SCL_HALF_CYC = TWR_SCL_HALF_NS / TWR_CLK_NS;
endpackage

// File: common/twr_if.sv
// Two-wire link between the register slave and its master.
// Assumes open-drain lines with pull-ups; the bench reads the wire levels.
`timescale 1ns/1ps
`default_nettype none
interface twr_if;
    logic scl_o;
    logic scl_oe;
    logic sda_m_o;
    logic sda_m_oe;
    logic sda_s_o;
    logic sda_s_oe;
    logic scl;
    logic sda;
    // Open drain: any enabled low driver pulls the line down
    assign scl = ~(scl_oe & ~scl_o);
    assign sda = ~((sda_m_oe & ~sda_m_o) | (sda_s_oe & ~sda_s_o));
    modport slave (input scl, input sda, output sda_s_o, output sda_s_oe);
    modport master (input scl, input sda, output scl_o, output scl_oe,
                    output sda_m_o, output sda_m_oe);
endinterface
`default_nettype wire

// File: hw/twr_slave.sv
// Register access slave of the two-wire link, with a small register file.
// Assumes scl and sda from the link are asynchronous to clk_sys.
`timescale 1ns/1ps
`default_nettype none
module twr_slave
    import twr_pkg::*;
#(
    parameter int DEPTH_LOG2 = TWR_REG_DEPTH_LOG2
) (
    input wire logic clk_sys,
    input wire logic rst,
    twr_if.slave link,
    output logic [15:0] ptr_q,
    output logic wr_stb_q,
    output logic [15:0] wr_addr_q,
    output logic [15:0] wr_data_q
);
    // ----------------------------------------------------------------
    // Input synchronisers and condition detect
    // ----------------------------------------------------------------
    logic [1:0] scl_s_q, sda_s_q;
    logic scl_q, sda_q;
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            scl_s_q <= 2'b11;
            sda_s_q <= 2'b11;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_s_q <= {scl_s_q[0], link.scl};
            sda_s_q <= {sda_s_q[0], link.sda};
            scl_q <= scl_s_q[1];
            sda_q <= sda_s_q[1];
        end
    end
    logic scl_rise, scl_fall, start_c, stop_c;
    assign scl_rise = scl_s_q[1] & ~scl_q;
    assign scl_fall = ~scl_s_q[1] & scl_q;
    assign start_c = scl_s_q[1] & scl_q & sda_q & ~sda_s_q[1];
    assign stop_c = scl_s_q[1] & scl_q & ~sda_q & sda_s_q[1];

    // ----------------------------------------------------------------
    // Protocol state
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        TWR_S_IDLE, TWR_S_RX, TWR_S_ACK, TWR_S_TX, TWR_S_MACK
    } twr_sst_t;
    twr_sst_t st_q;
    logic [7:0] sh_q;
    logic [3:0] bit_q;
    logic [2:0] idx_q;   // byte index within transfer
    logic rd_q;
    logic [7:0] hi_q;    // first byte of a pair
    logic sda_oe_q;
    logic [15:0] mem [0:(1<<DEPTH_LOG2)-1];

    function automatic logic [DEPTH_LOG2-1:0] wi(input logic [15:0] a);
        return a[DEPTH_LOG2-1:0];
    endfunction

    logic [15:0] rd_word;
    assign rd_word = mem[wi(ptr_q)];

    always_ff @(posedge clk_sys) begin
        wr_stb_q <= 1'b0;
        if (rst) begin
            st_q <= TWR_S_IDLE;
            sh_q <= 8'h00;
            bit_q <= 4'h0;
            idx_q <= 3'h0;
            rd_q <= 1'b0;
            hi_q <= 8'h00;
            sda_oe_q <= 1'b0;
            ptr_q <= TWR_REG_RESET;
            wr_addr_q <= 16'h0000;
            wr_data_q <= 16'h0000;
        end else if (start_c) begin
            st_q <= TWR_S_RX;
            bit_q <= 4'h0;
            idx_q <= 3'h0;
            rd_q <= 1'b0;
            sda_oe_q <= 1'b0;
        end else if (stop_c) begin
            st_q <= TWR_S_IDLE;
            sda_oe_q <= 1'b0;
        end else begin
            case (st_q)
                TWR_S_IDLE: begin
                    sda_oe_q <= 1'b0;
                end
                TWR_S_RX: begin
                    if (scl_rise) begin
                        sh_q <= {sh_q[6:0], sda_q};
                        bit_q <= bit_q + 4'h1;
                    end else if (scl_fall && bit_q == 4'h8) begin
                        bit_q <= 4'h0;
                        if (idx_q == 3'h0) begin
                            if (sh_q[7:1] == TWR_SLAVE_ADDR) begin
                                rd_q <= sh_q[0];
                                sda_oe_q <= 1'b1;
                                st_q <= TWR_S_ACK;
                            end else begin
                                st_q <= TWR_S_IDLE;
                            end
                        end else begin
                            sda_oe_q <= 1'b1;
                            st_q <= TWR_S_ACK;
                            if (idx_q == 3'h1) begin
                                hi_q <= sh_q;
                            end else if (idx_q == 3'h2) begin
                                ptr_q <= {hi_q, sh_q};
                            end else if (idx_q[0]) begin
                                hi_q <= sh_q;
                            end else begin
                                wr_stb_q <= 1'b1;
                                wr_addr_q <= ptr_q;
                                wr_data_q <= {hi_q, sh_q};
                                ptr_q <= ptr_q + 16'h1;
                            end
                        end
                    end
                end
                TWR_S_ACK: begin
                    if (scl_fall) begin
                        // Pairs after address repeat indices 3/4
                        if (idx_q == 3'h4) begin
                            idx_q <= 3'h3;
                        end else begin
                            idx_q <= idx_q + 3'h1;
                        end
                        if (rd_q) begin
                            // Current pointer, no address phase
                            sh_q <= rd_word[15:8];
                            sda_oe_q <= ~rd_word[15];
                            idx_q <= 3'h1;
                            st_q <= TWR_S_TX;
                        end else begin
                            sda_oe_q <= 1'b0;
                            st_q <= TWR_S_RX;
                        end
                    end
                end
                TWR_S_TX: begin
                    if (scl_fall) begin
                        if (bit_q == 4'h7) begin
                            bit_q <= 4'h0;
                            sda_oe_q <= 1'b0;
                            st_q <= TWR_S_MACK;
                        end else begin
                            bit_q <= bit_q + 4'h1;
                            sh_q <= {sh_q[6:0], 1'b0};
                            sda_oe_q <= ~sh_q[6];
                        end
                    end
                end
                TWR_S_MACK: begin
                    if (scl_rise) begin
                        // A word is complete whether acked or not
                        if (idx_q[0] == 1'b0) begin
                            ptr_q <= ptr_q + 16'h1;
                        end
                        if (sda_q) begin
                            st_q <= TWR_S_IDLE;
                        end else begin
                            idx_q <= ~idx_q;
                        end
                    end else if (scl_fall) begin
                        st_q <= TWR_S_TX;
                        sh_q <= idx_q[0] ? rd_word[15:8] : rd_word[7:0];
                        sda_oe_q <= idx_q[0] ? ~rd_word[15] : ~rd_word[7];
                    end
                end
                default: st_q <= TWR_S_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Register file; cleared so unwritten words read as reset value
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            for (int i = 0; i < (1 << DEPTH_LOG2); i++) begin
                mem[i] <= TWR_REG_RESET;
            end
        end else if (wr_stb_q) begin
            mem[wi(wr_addr_q)] <= wr_data_q;
        end
    end

    assign link.sda_s_o = 1'b0;
    assign link.sda_s_oe = sda_oe_q;
endmodule
`default_nettype wire

// File: hw/twr_master.sv
// Bus master end: runs one command of address, write or read words.
// Assumes the slave shares no clock; scl is divided from clk_sys.
`timescale 1ns/1ps
`default_nettype none
module twr_master
    import twr_pkg::*;
#(
    parameter int HALF = TWR_SCL_HALF_CYC
) (
    input wire logic clk_sys,
    input wire logic rst,
    twr_if.master link,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic cmd_read,
    input wire logic cmd_use_addr,
    input wire logic [15:0] cmd_addr,
    input wire logic [2:0] cmd_words,
    input wire logic [15:0] cmd_wdata,
    output logic rd_valid_q,
    output logic [15:0] rd_data_q,
    output logic nack_q
);
    typedef enum logic [2:0] {
        TWR_M_IDLE, TWR_M_START, TWR_M_BIT, TWR_M_STOP
    } twr_mst_t;
    twr_mst_t st_q;
    logic [15:0] cnt_q;
    logic ph_q;           // scl phase: 0 scl low, 1 scl low then high
    logic [8:0] sh_q;     // 8 bits then ack slot
    logic [3:0] bit_q;
    logic [3:0] byt_q;    // byte sequence number
    logic [3:0] last_q;
    logic rd_q, ua_q, rdph_q;
    logic [15:0] addr_q, wd_q, acc_q;
    logic [1:0] sda_s_q;
    logic scl_q, sda_q;

    assign cmd_ready = (st_q == TWR_M_IDLE);
    always_ff @(posedge clk_sys) begin
        if (rst) sda_s_q <= 2'b11;
        else sda_s_q <= {sda_s_q[0], link.sda};
    end

    function automatic logic [8:0] load(input logic [7:0] b);
        return {b, 1'b1};
    endfunction

    // Byte stream: addr byte, reg addr hi/lo, then data; read restarts
    logic [7:0] nb;
    always_comb begin
        nb = 8'hff;
        if (rdph_q) nb = 8'hff;
        else if (ua_q && byt_q == 4'h0) nb = addr_q[15:8];
        else if (ua_q && byt_q == 4'h1) nb = addr_q[7:0];
        else if (!byt_q[0]) nb = wd_q[15:8];
        else nb = wd_q[7:0];
    end

    always_ff @(posedge clk_sys) begin
        rd_valid_q <= 1'b0;
        if (rst) begin
            st_q <= TWR_M_IDLE;
            cnt_q <= 16'h0;
            ph_q <= 1'b1;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            sh_q <= 9'h1ff;
            bit_q <= 4'h0;
            byt_q <= 4'h0;
            last_q <= 4'h0;
            rd_q <= 1'b0;
            ua_q <= 1'b0;
            rdph_q <= 1'b0;
            addr_q <= 16'h0;
            wd_q <= 16'h0;
            acc_q <= 16'h0;
            rd_data_q <= 16'h0;
            nack_q <= 1'b0;
        end else if (cnt_q != 16'h0) begin
            cnt_q <= cnt_q - 16'h1;
        end else begin
            cnt_q <= 16'(HALF - 1);
            case (st_q)
                TWR_M_IDLE: begin
                    if (cmd_valid) begin
                        rd_q <= cmd_read;
                        ua_q <= cmd_use_addr | ~cmd_read;
                        addr_q <= cmd_addr;
                        wd_q <= cmd_wdata;
                        last_q <= {cmd_words, 1'b0};
                        rdph_q <= cmd_read & ~cmd_use_addr;
                        nack_q <= 1'b0;
                        st_q <= TWR_M_START;
                        sh_q <= load({TWR_SLAVE_ADDR,
                                      cmd_read & ~cmd_use_addr});
                    end
                end
                TWR_M_START: begin
                    // Sda falls alone while scl is high, then scl falls
                    if (!scl_q) begin
                        sda_q <= 1'b1;
                        scl_q <= 1'b1;
                    end else if (sda_q) begin
                        sda_q <= 1'b0;          // start or restart
                    end else begin
                        scl_q <= 1'b0;
                        bit_q <= 4'h0;
                        byt_q <= 4'h0;
                        ph_q <= 1'b0;
                        st_q <= TWR_M_BIT;
                    end
                end
                TWR_M_BIT: begin
                    if (!ph_q) begin
                        sda_q <= sh_q[8];
                        ph_q <= 1'b1;
                    end else if (!scl_q) begin
                        scl_q <= 1'b1;
                    end else begin
                        // Sample while scl is high, then drop it
                        ph_q <= 1'b0;
                        scl_q <= 1'b0;
                        sh_q <= {sh_q[7:0], 1'b1};
                        if (bit_q != 4'h8) begin
                            bit_q <= bit_q + 4'h1;
                            if (rdph_q && byt_q != 4'h0) begin
                                acc_q <= {acc_q[14:0], sda_s_q[1]};
                            end
                        end else begin
                            bit_q <= 4'h0;
                            byt_q <= byt_q + 4'h1;
                            if (rdph_q && byt_q != 4'h0 && !byt_q[0]) begin
                                rd_valid_q <= 1'b1;
                                rd_data_q <= acc_q;
                            end
                            if ((!rdph_q || byt_q == 4'h0) && sda_s_q[1]) begin
                                nack_q <= 1'b1;
                                st_q <= TWR_M_STOP;
                            end else if (rdph_q && byt_q == last_q) begin
                                st_q <= TWR_M_STOP;
                            end else if (!rdph_q && rd_q &&
                                         byt_q == 4'h2) begin
                                rdph_q <= 1'b1;
                                st_q <= TWR_M_START;
                                sh_q <= load({TWR_SLAVE_ADDR, 1'b1});
                            end else if (!rdph_q &&
                                         byt_q == 4'(last_q + 4'h2)) begin
                                st_q <= TWR_M_STOP;
                            end else if (rdph_q &&
                                         4'(byt_q + 4'h1) != last_q) begin
                                // Master acks until count reached
                                sh_q <= 9'h1fe;
                            end else if (rdph_q) begin
                                sh_q <= 9'h1ff;
                            end else begin
                                sh_q <= load(nb);
                            end
                        end
                    end
                end
                TWR_M_STOP: begin
                    if (!ph_q) begin
                        sda_q <= 1'b0;
                        ph_q <= 1'b1;
                    end else if (!scl_q) begin
                        scl_q <= 1'b1;
                    end else begin
                        sda_q <= 1'b1;
                        rdph_q <= 1'b0;
                        st_q <= TWR_M_IDLE;
                    end
                end
                default: st_q <= TWR_M_IDLE;
            endcase
        end
    end

    assign link.scl_o = 1'b0;
    assign link.scl_oe = ~scl_q;
    assign link.sda_m_o = 1'b0;
    assign link.sda_m_oe = ~sda_q;
endmodule
`default_nettype wire

// File: test/twr_link_checker.sv
// Checker watching the wires of the link between master end and slave end.
// Assumes one clk_sys domain and the link signals handed in plainly.
`timescale 1ns/1ps
`default_nettype none
module twr_link_checker
    import twr_pkg::*;
#(
    parameter int HALF = TWR_SCL_HALF_CYC
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic scl,
    input wire logic sda,
    input wire logic scl_oe,
    input wire logic sda_m_oe,
    input wire logic sda_s_o,
    input wire logic sda_s_oe
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    // ------------------------------------------------------------
    // Bit and byte position on the wire
    // ------------------------------------------------------------
    logic scl_q, sda_q, rise, start, stop, s_low, ack_slot, match, rd_dir;
    logic [3:0] bcnt_q;
    logic [2:0] nbyte_q;
    logic [7:0] sh_q, addr_q;
    logic [11:0] low_q;
    assign rise = scl & ~scl_q;
    assign start = scl & scl_q & sda_q & ~sda;
    assign stop = scl & scl_q & ~sda_q & sda;
    assign s_low = sda_s_oe & ~sda_s_o;
    assign ack_slot = rise && bcnt_q == 4'h8;
    assign match = addr_q[7:1] == TWR_SLAVE_ADDR;
    assign rd_dir = addr_q[0] == TWR_DIR_READ;
    always_ff @(posedge clk_sys) begin
        scl_q <= rst | scl;
        sda_q <= rst | sda;
    end
    always_ff @(posedge clk_sys) begin
        if (rst || start) begin
            bcnt_q <= 4'h0;
            nbyte_q <= 3'h0;
        end else if (rise) begin
            bcnt_q <= (bcnt_q == 4'h8) ? 4'h0 : bcnt_q + 4'h1;
            // Saturates at 7: properties need only first versus later bytes, c_long the count of 7
            if (bcnt_q == 4'h8 && nbyte_q != 3'h7) begin
                nbyte_q <= nbyte_q + 3'h1;
            end
        end
    end
    always_ff @(posedge clk_sys) begin
        if (rise) begin
            sh_q <= {sh_q[6:0], sda};
        end
        if (rise && bcnt_q == 4'h7 && nbyte_q == 3'h0) begin
            addr_q <= {sh_q[6:0], sda};
        end
    end
    always_ff @(posedge clk_sys) begin
        if (rst || !s_low) begin
            low_q <= 12'h000;
        end else if (low_q != 12'hfff) begin
            low_q <= low_q + 12'h001;
        end
    end
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    property p_addr_ack;
        ack_slot && nbyte_q == 3'h0 && match |-> !sda [*2];
    endproperty
    a_addr_ack: assert property (p_addr_ack)
        else $error("address byte not acknowledged");
    property p_write_ack;
        ack_slot && nbyte_q != 3'h0 && match && !rd_dir |-> !sda;
    endproperty
    a_write_ack: assert property (p_write_ack)
        else $error("written byte not acknowledged");
    property p_read_slot;
        ack_slot && nbyte_q != 3'h0 && rd_dir |-> !s_low;
    endproperty
    a_read_slot: assert property (p_read_slot)
        else $error("slave drove the master acknowledge slot");
    property p_nack_release;
        ack_slot && nbyte_q != 3'h0 && rd_dir && sda |-> ##1 !s_low [*8];
    endproperty
    a_nack_release: assert property (p_nack_release)
        else $error("slave kept data low after no-acknowledge");
    property p_quiet_high;
        scl && scl_q |-> $stable(sda_s_oe & ~sda_s_o);
    endproperty
    a_quiet_high: assert property (p_quiet_high)
        else $error("slave changed data while clock high");
    property p_low_bound;
        // Ack slot plus a zero byte is nine bit periods; bound is ten bit periods of three ticks
        low_q < 12'(30 * HALF);
    endproperty
    a_low_bound: assert property (p_low_bound)
        else $error("slave held data low too long");
    property p_reset_idle;
        $fell(rst) |-> !sda_s_oe && !scl_oe && !sda_m_oe;
    endproperty
    a_reset_idle: assert property (p_reset_idle)
        else $error("line driven right after reset");
    property p_stop_idle;
        stop |-> !sda_s_oe [*4];
    endproperty
    a_stop_idle: assert property (p_stop_idle)
        else $error("slave driving after stop");
    c_restart: cover property (start && nbyte_q != 3'h0);
    c_nack: cover property (ack_slot && nbyte_q != 3'h0 && rd_dir && sda);
    c_long: cover property (rise && nbyte_q == 3'h7);
endmodule
`default_nettype wire

// File: test/two_wire_register_access_slave_tb.sv
// Bench: master end and slave end joined, plus a second slave under a master driven by hand.
// Assumes the package constants and link interface of the common folder.
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) \
    begin \
        checked++; \
        if ((got) !== (exp)) begin \
            miscompares++; \
            $display("[ERR] %0t got %h want %h", $time, got, exp); \
        end \
    end
module two_wire_register_access_slave_tb
    import twr_pkg::*;
();
    localparam int HALF = 4;
    logic clk_sys = 1'b0, rst = 1'b1, cmd_valid = 1'b0, cmd_read = 1'b0;
    logic cmd_use_addr = 1'b0, bb_scl = 1'b1, bb_sda = 1'b1;
    logic [15:0] cmd_addr = 16'h0000, cmd_wdata = 16'h0000;
    logic [2:0] cmd_words = 3'h1;
    logic cmd_ready, rd_valid_q, nack_q, wr_stb_q, mon_scl = 1'b1;
    logic mon_sda = 1'b1;
    logic [15:0] rd_data_q, ptr_q, wr_addr_q, wr_data_q;
    logic [15:0] rd_q[$], wa_q[$], wd_q[$];
    logic [7:0] mon_byte, first_byte;
    int checked = 0, miscompares = 0, mon_cnt = 0, start_cnt = 0, base = 0;
    twr_if link_a();
    twr_if link_b();
    always #25 clk_sys = ~clk_sys;
    // Hand-driven master on the second link, open drain
    assign link_b.scl_o = 1'b0;
    assign link_b.scl_oe = ~bb_scl;
    assign link_b.sda_m_o = 1'b0;
    assign link_b.sda_m_oe = ~bb_sda;
    twr_slave u_twr_slave (.clk_sys(clk_sys), .rst(rst), .link(link_a),
        .ptr_q(ptr_q), .wr_stb_q(wr_stb_q), .wr_addr_q(wr_addr_q),
        .wr_data_q(wr_data_q));
    twr_slave u_twr_slave_2 (.clk_sys(clk_sys), .rst(rst), .link(link_b),
        .ptr_q(), .wr_stb_q(), .wr_addr_q(), .wr_data_q());
    twr_master #(.HALF(HALF)) u_twr_master (.clk_sys(clk_sys), .rst(rst),
        .link(link_a), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .cmd_read(cmd_read), .cmd_use_addr(cmd_use_addr),
        .cmd_addr(cmd_addr), .cmd_words(cmd_words), .cmd_wdata(cmd_wdata),
        .rd_valid_q(rd_valid_q), .rd_data_q(rd_data_q), .nack_q(nack_q));
    twr_link_checker #(.HALF(HALF)) u_twr_link_checker (.clk_sys(clk_sys),
        .rst(rst), .scl(link_a.scl), .sda(link_a.sda),
        .scl_oe(link_a.scl_oe), .sda_m_oe(link_a.sda_m_oe),
        .sda_s_o(link_a.sda_s_o), .sda_s_oe(link_a.sda_s_oe));
    // ------------------------------------------------------------
    // Capture of words and of the last address byte on the wire
    // ------------------------------------------------------------
    always @(posedge clk_sys) begin
        if (wr_stb_q === 1'b1) begin
            wa_q.push_back(wr_addr_q);
            wd_q.push_back(wr_data_q);
        end
        if (rd_valid_q === 1'b1) begin
            rd_q.push_back(rd_data_q);
        end
        mon_scl <= link_a.scl;
        mon_sda <= link_a.sda;
        if (link_a.scl && mon_scl && mon_sda && !link_a.sda) begin
            mon_cnt <= 0;
            start_cnt <= start_cnt + 1;
        end else if (link_a.scl && !mon_scl) begin
            mon_cnt <= mon_cnt + 1;
            mon_byte <= {mon_byte[6:0], link_a.sda};
            if (mon_cnt == 7) begin
                first_byte <= {mon_byte[6:0], link_a.sda};
            end
        end
    end
    // ------------------------------------------------------------
    // Drivers
    // ------------------------------------------------------------
    task automatic run_cmd(input logic rd, input logic ua,
        input logic [15:0] a, input logic [2:0] n, input logic [15:0] d);
        int t;
        wa_q.delete();
        wd_q.delete();
        rd_q.delete();
        base = start_cnt;
        @(posedge clk_sys);
        cmd_valid <= 1'b1;
        cmd_read <= rd;
        cmd_use_addr <= ua;
        cmd_addr <= a;
        cmd_words <= n;
        cmd_wdata <= d;
        t = 0;
        do begin
            @(posedge clk_sys);
            t++;
        end while (cmd_ready !== 1'b0 && t < 100);
        cmd_valid <= 1'b0;
        do begin
            @(posedge clk_sys);
            t++;
        end while (cmd_ready !== 1'b1 && t < 3000);
        repeat (8) @(posedge clk_sys);
        `CHK(cmd_ready, 1'b1)
        `CHK(nack_q, 1'b0)
    endtask
    // Scl period 8 cycles, 400 ns; data moves only while scl is low
    task automatic bb_bit(input logic b, output logic r);
        @(posedge clk_sys) bb_sda <= b;
        repeat (3) @(posedge clk_sys);
        bb_scl <= 1'b1;
        repeat (3) @(posedge clk_sys);
        r = link_b.sda;
        @(posedge clk_sys) bb_scl <= 1'b0;
    endtask
    // Start when last is 0, stop when last is 1
    task automatic bb_cond(input logic last);
        @(posedge clk_sys) bb_sda <= ~last;
        repeat (3) @(posedge clk_sys);
        bb_scl <= 1'b1;
        repeat (4) @(posedge clk_sys);
        bb_sda <= last;
        repeat (4) @(posedge clk_sys);
        bb_scl <= last;
    endtask
    task automatic bb_byte(input logic [7:0] v, input logic m_ack,
        output logic [7:0] r, output logic a);
        for (int i = 7; i >= 0; i--) bb_bit(v[i], r[i]);
        bb_bit(m_ack, a);
    endtask
    task automatic print_verdict();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_writes();
        `CHK({link_a.scl, link_a.sda}, 2'b11)
        `CHK(ptr_q, 16'h0000)
        run_cmd(1'b0, 1'b1, 16'h0010, 3'h1, 16'hbeef);
        `CHK(wa_q.size(), 1)
        `CHK(wa_q[0], 16'h0010)
        `CHK(wd_q[0], 16'hbeef)
        `CHK(ptr_q, 16'h0011)
        `CHK(first_byte, {TWR_SLAVE_ADDR, TWR_DIR_WRITE})
        // Crosses the end of the 64-word file
        run_cmd(1'b0, 1'b1, 16'h003e, 3'h3, 16'h1234);
        `CHK(wa_q.size(), 3)
        for (int i = 0; i < 3; i++) begin
            `CHK(wa_q[i], 16'(16'h003e + i))
            `CHK(wd_q[i], 16'h1234)
        end
        `CHK(ptr_q, 16'h0041)
    endtask
    task automatic t_reads();
        run_cmd(1'b1, 1'b1, 16'h0010, 3'h1, 16'h0000);
        `CHK(rd_q.size(), 1)
        `CHK(rd_q[0], 16'hbeef)
        `CHK(wa_q.size(), 0)
        `CHK(first_byte, {TWR_SLAVE_ADDR, TWR_DIR_READ})
        `CHK(start_cnt - base, 2)
        run_cmd(1'b1, 1'b1, 16'h000f, 3'h2, 16'h0000);
        `CHK(rd_q[0], TWR_REG_RESET)
        `CHK(rd_q[1], 16'hbeef)
        run_cmd(1'b1, 1'b1, 16'h003e, 3'h1, 16'h0000);
        `CHK(ptr_q, 16'h003f)
        run_cmd(1'b1, 1'b0, 16'h0000, 3'h3, 16'h0000);
        `CHK(start_cnt - base, 1)
        `CHK(rd_q.size(), 3)
        `CHK(rd_q[0], 16'h1234)
        `CHK(rd_q[1], 16'h1234)
        `CHK(rd_q[2], TWR_REG_RESET)
        `CHK(ptr_q, 16'h0042)
    endtask
    task automatic t_faults();
        logic [7:0] r;
        logic a;
        bb_cond(1'b0);
        bb_byte({TWR_SLAVE_ADDR ^ 7'h01, TWR_DIR_WRITE}, 1'b1, r, a);
        `CHK(a, 1'b1)
        bb_byte(8'h00, 1'b1, r, a);
        `CHK(a, 1'b1)
        bb_cond(1'b1);
        bb_cond(1'b0);
        bb_byte({TWR_SLAVE_ADDR, TWR_DIR_WRITE}, 1'b1, r, a);
        `CHK(a, 1'b0)
        for (int i = 0; i < 2; i++) begin
            bb_byte(8'h00, 1'b1, r, a);
            `CHK(a, 1'b0)
        end
        bb_cond(1'b0);
        bb_byte({TWR_SLAVE_ADDR, TWR_DIR_READ}, 1'b1, r, a);
        `CHK(a, 1'b0)
        // No-acknowledge in mid-word: the slave must let go at once
        bb_byte(8'hff, 1'b1, r, a);
        `CHK(r, TWR_REG_RESET[15:8])
        bb_bit(1'b1, a);
        `CHK(a, 1'b1)
        bb_cond(1'b1);
    endtask
    initial begin
        repeat (12) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (4) @(posedge clk_sys);
        t_writes();
        t_reads();
        t_faults();
        print_verdict();
    end
    // Whole run needs about 5300 cycles
    initial begin
        repeat (40000) @(posedge clk_sys);
        miscompares++;
        $display("[ERR] %0t watchdog expired", $time);
        print_verdict();
    end
endmodule
`default_nettype wire
